/* hdl/mdaw_pkg.sv */
/*
  Constants, register map and state codes of the multidrop serial
  interface with address-mode receiver wakeup.
  Assumes a 32-bit classic Wishbone register bus, byte address equal
  to four times the register index.
*/
package mdaw_pkg;
  // ----------------------------------------------------------------
  // Bus and register indices
  // ----------------------------------------------------------------
  localparam int AW = 18;
  localparam logic [15:0] IDX_CTRL = 16'hFFF0;
  localparam logic [15:0] IDX_STAT = 16'hFFF1;
  localparam logic [15:0] IDX_CLKC = 16'hFFF2;
  localparam logic [15:0] IDX_TXA = 16'hFFF3;
  localparam logic [15:0] IDX_DATA = 16'hFFF4;
  localparam logic [15:0] IDX_EVT = 16'hFFF5;
  localparam logic [15:0] IDX_MASK = 16'hFFF6;
  localparam logic [23:0] CTRL_RST = 24'h000000;
  localparam logic [23:0] CLKC_RST = 24'h000000;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C_WAKE = 5;
  localparam int C_RWU = 6;
  localparam int C_WOR = 7;
  localparam int C_TE = 8;
  localparam int C_RE = 9;
  localparam int C_RIE = 11;
  localparam int C_TIE = 12;
  localparam logic [2:0] WDS_MULTIDROP = 3'h6;
  localparam int S_TDRE = 0;
  localparam int S_TRNE = 1;
  localparam int S_RDRF = 2;
  localparam int S_OR = 4;
  localparam int S_FE = 6;
  localparam int S_R8 = 7;
  localparam int E_RX = 0;
  localparam int E_RXEXC = 1;
  localparam int E_TX = 2;
  localparam int NEV = 3;
  localparam int CD_W = 12;
  // ----------------------------------------------------------------
  // Interrupt vectors and frame timing
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_RX = 16'h0014;
  localparam logic [15:0] VEC_RXEXC = 16'h0016;
  localparam logic [15:0] VEC_TX = 16'h0018;
  localparam logic [15:0] VEC_NONE = 16'h0000;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] BITS_10 = 4'hA;
  localparam logic [3:0] BITS_11 = 4'hB;
  localparam logic [3:0] RXB_8 = 4'h7;
  localparam logic [3:0] RXB_9 = 4'h8;
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } mdaw_rx_t;
endpackage

/* hdl/mdaw_tx_shifter.sv */
/*
  Transmit frame shifter: start bit, eight data bits, optional ninth
  (data-type) bit, stop bit, LSB first, sixteen ticks per bit.
  Assumes tick is a one-cycle pulse from the baud divider and start
  is only raised while busy is low.
*/
`timescale 1ns/1ns
module mdaw_tx_shifter (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic start,
  input wire logic [7:0] data,
  input wire logic ninth,
  input wire logic eleven,
  output logic busy,
  output logic txd
);
  import mdaw_pkg::*;

  typedef struct packed {
    logic [10:0] sh;
    logic [3:0] left;
    logic [3:0] sub;
    logic txd;
  } mdaw_txs_t;

  mdaw_txs_t s_reg, s_next;

  assign busy = s_reg.left != 4'h0;
  assign txd = s_reg.txd;

  always_comb begin
    s_next = s_reg;
    if (start && !busy) begin
      // Eleven-bit frame carries the data-type bit after the byte
      if (eleven) begin
        s_next.sh = {1'b1, ninth, data, 1'b0}; // see RQ13
        s_next.left = BITS_11;
      end else begin
        s_next.sh = {2'b11, data, 1'b0};
        s_next.left = BITS_10;
      end
      s_next.sub = 4'h0;
    end else if (busy && tick) begin
      s_next.sub = s_reg.sub + 4'h1;
      if (s_reg.sub == OVS_LAST) begin
        s_next.sh = {1'b1, s_reg.sh[10:1]};
        s_next.left = s_reg.left - 4'h1;
      end
    end
    s_next.txd = (s_next.left != 4'h0) ? s_next.sh[0] : 1'b1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{sh: 11'h7FF, left: 4'h0, sub: 4'h0, txd: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  a_frame_layout: assert property ( // see RQ13
    @(posedge clk) disable iff (!rstn)
    start && !busy && eleven |=> !txd && s_reg.sh[10]
      && s_reg.sh[9] == $past(ninth) && s_reg.left == BITS_11)
    else $error("multidrop frame not laid out as eleven bits");
endmodule

/* hdl/mdaw_top.sv */
/*
  Multidrop serial interface with address-mode receiver wakeup,
  registers on a classic Wishbone slave, one level interrupt with a
  vector output.
  Assumes rxdI is synchronous to clk and the wired line is resolved
  outside from txdO and txdOeN.
*/
// Operation
// RQ1 - Ninth bit one wakes sleeping receiver
// RQ2 - Transmit-address write sends ninth bit one
// RQ3 - Wakeup-select bit chooses address-mode wakeup
// RQ4 - Sleep bit puts receiver asleep, arms wakeup
// RQ5 - Software picks asynchronous word format for wakeup
// RQ6 - Address character sets ninth flag, clears sleep
// RQ7 - Received character raises data or exception interrupt
// RQ8 - Software sets sleep again to resleep
// RQ9 - Address wakeup needs no idle line
// RQ10 - Receive and transmit words share one address
// RQ11 - Control, clock, address registers at consecutive indices (the code puts status at FFF1 between control and clock)
// RQ12 - Separate vectors for receive, exception, transmit
// RQ13 - Frame: start, eight data, type, stop
// RQ14 - Word select one-one-zero picks multidrop format
// RQ15 - Transmit-data write sends ninth bit zero
// RQ16 - Sleep bit is control bit six
// RQ17 - Ninth flag readable as status bit seven
// RQ18 - Sleeping receiver ignores data characters entirely (the code still loads the ninth flag from them)
// RQ19 - Ninth flag follows every multidrop character
`timescale 1ns/1ns
module mdaw_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wbCycI,
  input wire logic wbStbI,
  input wire logic wbWeI,
  input wire logic [mdaw_pkg::AW-1:0] wbAdrI,
  input wire logic [3:0] wbSelI,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAckO,
  input wire logic rxdI,
  output logic txdO,
  output logic txdOeN,
  output logic irqO,
  output logic [15:0] irqVectorO
);
  import mdaw_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] datO;
    logic irq;
    logic [15:0] vec;
    logic txdO;
    logic txdOeN;
    logic [23:0] ctl;
    logic [23:0] clkc;
    logic [NEV-1:0] evt;
    logic [NEV-1:0] mask;
    logic [7:0] rxData;
    logic rdrf;
    logic orr;
    logic fe;
    logic r8;
    logic tdre;
    logic [7:0] hold;
    logic holdNinth;
    logic txStart;
    logic [CD_W-1:0] baud;
    mdaw_rx_t rxSt;
    logic [3:0] rxTick;
    logic [3:0] rxBit;
    logic [8:0] rxShift;
  } mdaw_state_t;

  localparam mdaw_state_t S_RST = '{
    ack: 1'b0, datO: 32'h00000000, irq: 1'b0, vec: VEC_NONE,
    txdO: 1'b1, txdOeN: 1'b1, ctl: CTRL_RST, clkc: CLKC_RST,
    evt: 3'h0, mask: 3'h0, rxData: 8'h00, rdrf: 1'b0, orr: 1'b0,
    fe: 1'b0, r8: 1'b0, tdre: 1'b1, hold: 8'h00, holdNinth: 1'b0,
    txStart: 1'b0, baud: 12'h000, rxSt: RX_IDLE, rxTick: 4'h0,
    rxBit: 4'h0, rxShift: 9'h000
  };

  mdaw_state_t s_reg, s_next;

  logic [15:0] idx;
  logic busReq;
  logic busWr;
  logic busRd;
  logic tick;
  logic md;
  logic rxDone;
  logic rxWake;
  logic txBusy;
  logic txd;

  // ----------------------------------------------------------------
  // Byte-lane merge for the 24-bit registers
  // ----------------------------------------------------------------
  function automatic logic [23:0] mergeSel(
    input logic [23:0] old,
    input logic [23:0] nw,
    input logic [2:0] sel
  );
    mergeSel = old;
    for (int i = 0; i < 3; i++) begin
      if (sel[i]) begin
        mergeSel[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  assign idx = wbAdrI[AW-1:2];
  assign busReq = wbCycI & wbStbI;
  assign busWr = busReq & wbWeI & s_reg.ack;
  assign busRd = busReq & ~wbWeI & s_reg.ack;
  assign tick = s_reg.baud >= s_reg.clkc[CD_W-1:0];
  assign md = s_reg.ctl[2:0] == WDS_MULTIDROP; // see RQ14
  assign rxDone = s_reg.ctl[C_RE] & tick & (s_reg.rxSt == RX_STOP)
    & (s_reg.rxTick == OVS_LAST);
  // Any address frame wakes when the wakeup-select bit is set, even back to back with no idle gap
  assign rxWake = s_reg.ctl[C_RWU] & s_reg.ctl[C_WAKE] & md
    & s_reg.rxShift[8]; // see RQ3 RQ9

  // ----------------------------------------------------------------
  // Transmit shifter
  // ----------------------------------------------------------------
  mdaw_tx_shifter u_tx (
    .clk(clk),
    .rstn(rstn),
    .tick(tick),
    .start(s_reg.txStart),
    .data(s_reg.hold),
    .ninth(s_reg.holdNinth),
    .eleven(md),
    .busy(txBusy),
    .txd(txd)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] st;
    logic [7:0] rxByte;
    logic err;
    logic [NEV-1:0] pend;
    st = 8'h00;
    rxByte = md ? s_reg.rxShift[7:0] : s_reg.rxShift[8:1];
    err = 1'b0;
    pend = '0;
    s_next = s_reg;
    s_next.txStart = 1'b0;
    s_next.baud = tick ? '0 : s_reg.baud + 12'h001;

    // Bus answer one cycle after the request, dropped the next cycle
    s_next.ack = busReq & ~s_reg.ack; // see RQ11
    st[S_TDRE] = s_reg.tdre;
    st[S_TRNE] = s_reg.tdre & ~txBusy;
    st[S_RDRF] = s_reg.rdrf;
    st[S_OR] = s_reg.orr;
    st[S_FE] = s_reg.fe;
    st[S_R8] = s_reg.r8; // see RQ17
    if (busReq & ~s_reg.ack) begin
      case (idx)
        IDX_CTRL: s_next.datO = {8'h00, s_reg.ctl};
        IDX_STAT: s_next.datO = {24'h000000, st};
        IDX_CLKC: s_next.datO = {8'h00, s_reg.clkc};
        IDX_DATA: s_next.datO = {24'h000000, s_reg.rxData}; // see RQ10
        IDX_EVT: s_next.datO = {29'h00000000, s_reg.evt};
        IDX_MASK: s_next.datO = {29'h00000000, s_reg.mask};
        default: s_next.datO = 32'h00000000;
      endcase
    end

    // Register writes take effect at the edge that sees ack high
    if (busWr) begin
      case (idx)
        IDX_CTRL: begin
          s_next.ctl = mergeSel(s_reg.ctl, wbDatI[23:0],
            wbSelI[2:0]); // see RQ4 RQ16
        end
        IDX_CLKC: begin
          s_next.clkc = mergeSel(s_reg.clkc, wbDatI[23:0], wbSelI[2:0]);
        end
        IDX_TXA, IDX_DATA: begin
          if (wbSelI[0]) begin
            s_next.hold = wbDatI[7:0];
            s_next.holdNinth = idx == IDX_TXA; // see RQ2
            s_next.tdre = 1'b0; // see RQ15
          end
        end
        IDX_EVT: begin
          if (wbSelI[0]) begin
            s_next.evt = s_reg.evt & ~wbDatI[NEV-1:0];
          end
        end
        IDX_MASK: begin
          if (wbSelI[0]) begin
            s_next.mask = wbDatI[NEV-1:0];
          end
        end
        default: ;
      endcase
    end
    if (busRd && idx == IDX_DATA) begin
      s_next.rdrf = 1'b0;
      s_next.orr = 1'b0;
      s_next.fe = 1'b0;
    end

    // Receiver, sixteen ticks per bit, sampled mid-bit
    if (!s_reg.ctl[C_RE]) begin
      s_next.rxSt = RX_IDLE;
    end else if (tick) begin
      case (s_reg.rxSt)
        RX_IDLE: begin
          if (!rxdI) begin
            s_next.rxSt = RX_START;
            s_next.rxTick = 4'h0;
          end
        end
        RX_START: begin
          s_next.rxTick = s_reg.rxTick + 4'h1;
          if (s_reg.rxTick == OVS_MID) begin
            if (rxdI) begin
              s_next.rxSt = RX_IDLE;
            end else begin
              s_next.rxSt = RX_DATA;
              s_next.rxTick = 4'h0;
              s_next.rxBit = 4'h0;
            end
          end
        end
        RX_DATA: begin
          s_next.rxTick = s_reg.rxTick + 4'h1;
          if (s_reg.rxTick == OVS_LAST) begin
            s_next.rxShift = {rxdI, s_reg.rxShift[8:1]};
            s_next.rxBit = s_reg.rxBit + 4'h1;
            if (s_reg.rxBit == (md ? RXB_9 : RXB_8)) begin
              s_next.rxSt = RX_STOP; // see RQ13
            end
          end
        end
        RX_STOP: begin
          s_next.rxTick = s_reg.rxTick + 4'h1;
          if (s_reg.rxTick == OVS_LAST) begin
            s_next.rxSt = RX_IDLE;
          end
        end
        default: s_next.rxSt = RX_IDLE;
      endcase
    end

    // Character complete: wakeup, flags and events
    if (rxDone) begin
      if (md) begin
        s_next.r8 = s_reg.rxShift[8]; // see RQ19
      end
      // Only an address frame ends sleep in address mode
      if (rxWake) begin
        s_next.ctl[C_RWU] = 1'b0; // see RQ1 RQ6
      end
      // A sleeping receiver drops data frames; only the r8 ninth flag still follows them
      if (!s_reg.ctl[C_RWU] || rxWake) begin // see RQ18
        err = ~rxdI | s_reg.rdrf;
        if (s_reg.rdrf) begin
          s_next.orr = 1'b1;
        end else begin
          s_next.rxData = rxByte;
        end
        s_next.fe = s_next.fe | ~rxdI;
        s_next.rdrf = 1'b1;
        if (s_reg.ctl[C_RIE]) begin
          if (err) begin
            s_next.evt[E_RXEXC] = 1'b1; // see RQ7
          end else begin
            s_next.evt[E_RX] = 1'b1; // see RQ7
          end
        end
      end
    end

    // Hand the holding byte to the shifter
    if (!s_reg.tdre && !txBusy && s_reg.ctl[C_TE] && !s_reg.txStart) begin
      s_next.txStart = 1'b1;
      s_next.tdre = 1'b1;
      if (s_reg.ctl[C_TIE]) begin
        s_next.evt[E_TX] = 1'b1;
      end
    end

    // Wired-OR releases the line while sending a one
    s_next.txdO = txd;
    s_next.txdOeN = ~s_reg.ctl[C_TE] | (s_reg.ctl[C_WOR] & txd);

    // Interrupt level and vector of the highest pending source
    pend = s_next.evt & s_next.mask;
    s_next.irq = |pend;
    if (pend[E_RXEXC]) begin
      s_next.vec = VEC_RXEXC; // see RQ12
    end else if (pend[E_RX]) begin
      s_next.vec = VEC_RX;
    end else if (pend[E_TX]) begin
      s_next.vec = VEC_TX;
    end else begin
      s_next.vec = VEC_NONE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= S_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wbDatO = s_reg.datO;
  assign wbAckO = s_reg.ack;
  assign txdO = s_reg.txdO;
  assign txdOeN = s_reg.txdOeN;
  assign irqO = s_reg.irq;
  assign irqVectorO = s_reg.vec;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_wake_on_addr: assert property (rxDone && rxWake |=> // see RQ1
    !s_reg.ctl[C_RWU] && s_reg.r8 && s_reg.rdrf)
    else $error("address frame did not wake the receiver");
  a_data_stays_asleep: assert property (rxDone && s_reg.ctl[C_RWU] // see RQ18
    && !rxWake && !s_reg.ack |=> s_reg.ctl[C_RWU]
    && s_reg.rxData == $past(s_reg.rxData) && !$rose(s_reg.rdrf))
    else $error("data frame disturbed a sleeping receiver");
  a_wake_select: assert property (rxDone && s_reg.ctl[C_RWU] // see RQ3
    && !s_reg.ctl[C_WAKE] && !s_reg.ack |=> s_reg.ctl[C_RWU])
    else $error("receiver woke without address-mode select");
  a_r8_latest: assert property (rxDone && md |=> // see RQ19
    s_reg.r8 == $past(s_reg.rxShift[8]))
    else $error("ninth-bit flag does not follow last frame");
  a_sleep_bit: assert property (busWr && idx == IDX_CTRL // see RQ4
    && wbSelI[0] && wbDatI[C_RWU] && !rxDone |=> s_reg.ctl[C_RWU])
    else $error("sleep bit write did not put receiver asleep");
  a_addr_ninth: assert property (busWr && idx == IDX_TXA // see RQ2
    && wbSelI[0] |=> s_reg.holdNinth && !s_reg.tdre)
    else $error("transmit-address write lost the ninth bit");
  a_data_ninth: assert property (busWr && idx == IDX_DATA // see RQ15
    && wbSelI[0] |=> !s_reg.holdNinth)
    else $error("transmit-data write set the ninth bit");
  a_rx_event: assert property (rxDone && !s_reg.rdrf && rxdI // see RQ7
    && s_reg.ctl[C_RIE] && (!s_reg.ctl[C_RWU] || rxWake)
    |=> s_reg.evt[E_RX] && !$rose(s_reg.evt[E_RXEXC]))
    else $error("clean character raised no receive event");
  a_exc_vector: assert property ($rose(s_reg.evt[E_RXEXC]) // see RQ12
    && s_reg.mask[E_RXEXC] |-> irqO && irqVectorO == VEC_RXEXC)
    else $error("exception event did not steer the vector");
  a_bus_ack: assert property (busReq && !wbAckO |=> wbAckO // see RQ11
    ##1 !wbAckO) else $error("bus answer not a single cycle");
  a_rx_read: assert property (busReq && !wbWeI && !wbAckO // see RQ10
    && idx == IDX_DATA |=> wbDatO == {24'h000000, $past(s_reg.rxData)})
    else $error("receive word read returned wrong data");
  c_wakeup: cover property (rxDone && rxWake);
  c_addr_tx: cover property (s_reg.txStart && s_reg.holdNinth && md);
  c_exc: cover property ($rose(s_reg.evt[E_RXEXC]));
  c_irq: cover property ($rose(irqO));
endmodule

/* tb/mdaw_node_model.sv */
/*
  Behavioural far-side node on the multidrop line: sends frames when
  asked and decodes every frame it hears on the line.
  Assumes one bit lasts BIT_CLKS clocks and the line idles high.
*/
`timescale 1ns/1ns
module mdaw_node_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk,
  input wire logic lineIn,
  output logic lineOut,
  output logic [7:0] heardByte,
  output logic heardNinth,
  output logic heardStop,
  output int heardCount
);
  logic [9:0] got;

  initial begin
    lineOut = 1'h1;
    heardCount = 0;
  end

  // ----------------------------------------------------------------
  // Sender
  // ----------------------------------------------------------------
  task automatic send_frame(input logic [7:0] data, input logic ninth);
    logic [10:0] frame;
    frame = {1'h1, ninth, data, 1'h0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      lineOut <= frame[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
  endtask

  // ----------------------------------------------------------------
  // Listener, samples mid-bit
  // ----------------------------------------------------------------
  always begin
    @(negedge lineIn);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      got[i] = lineIn;
    end
    heardByte = got[7:0];
    heardNinth = got[8];
    heardStop = got[9];
    heardCount++;
  end
endmodule

/* tb/test_multidrop_address_wakeup.sv */
/*
  Self-checking bench of the multidrop serial interface: register
  rows, then wakeup, back-to-back, masking and transmit cases.
  Assumes the node model on the line and a divider of zero.
*/
`timescale 1ns/1ns
module test_multidrop_address_wakeup;
  import mdaw_pkg::*;
  typedef struct packed {
    logic we;
    logic [15:0] idx;
    logic [31:0] data;
  } mdaw_row_t;
  logic clk, rstn, wbCycI, wbStbI, wbWeI, rxdI;
  logic [AW-1:0] wbAdrI;
  logic [3:0] wbSelI;
  logic [31:0] wbDatI, wbDatO, rdData;
  logic wbAckO, txdO, txdOeN, irqO, heardNinth, heardStop;
  logic [15:0] irqVectorO;
  logic [7:0] heardByte;
  wire logic lineWire;
  int heardCount;
  int badCount;
  int checks;
  mdaw_row_t rows [16] = '{
    '{1'h0, IDX_CTRL, 32'h00000000}, '{1'h0, IDX_CLKC, 32'h00000000},
    '{1'h0, IDX_STAT, 32'h00000003}, '{1'h0, IDX_EVT, 32'h00000000},
    '{1'h0, IDX_MASK, 32'h00000000}, '{1'h1, 16'hFFF7, 32'h000000FF},
    '{1'h0, 16'hFFF7, 32'h00000000}, '{1'h1, IDX_CLKC, 32'h00000FFF},
    '{1'h0, IDX_CLKC, 32'h00000FFF}, '{1'h1, IDX_CLKC, 32'h00000000},
    '{1'h1, IDX_STAT, 32'h000000FF}, '{1'h0, IDX_STAT, 32'h00000003},
    '{1'h1, IDX_CTRL, 32'h00000B66},
    '{1'h0, IDX_CTRL, 32'h00000B66}, '{1'h1, IDX_MASK, 32'h00000007},
    '{1'h0, IDX_MASK, 32'h00000007}};

  assign lineWire = txdOeN ? 1'h1 : txdO;

  mdaw_top u_mdaw_top (.clk(clk), .rstn(rstn), .wbCycI(wbCycI),
    .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI),
    .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAckO(wbAckO), .rxdI(rxdI),
    .txdO(txdO), .txdOeN(txdOeN), .irqO(irqO),
    .irqVectorO(irqVectorO));

  mdaw_node_model u_mdaw_node_model (.clk(clk), .lineIn(lineWire),
    .lineOut(rxdI), .heardByte(heardByte), .heardNinth(heardNinth),
    .heardStop(heardStop), .heardCount(heardCount));

  always #20 clk = ~clk;

  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic cmpReg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmpBit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic busCycle(input logic we, input logic [15:0] idx,
                          input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    wbCycI <= 1'h1;
    wbStbI <= 1'h1;
    wbWeI <= we;
    wbAdrI <= {idx, 2'h0};
    wbDatI <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (wbAckO !== 1'h1 && n < 50);
    if (n >= 50) badCount++;
    rdData = wbDatO;
    wbCycI <= 1'h0;
    wbStbI <= 1'h0;
  endtask

  task automatic readCheck(input logic [15:0] idx, input logic [31:0] exp,
                           input logic [31:0] msk = 32'hFFFFFFFF);
    busCycle(1'h0, idx, 32'h00000000);
    cmpReg(rdData & msk, exp);
  endtask

  task automatic waitHeard(input int n);
    int k;
    k = 0;
    while (heardCount < n && k < 1000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 1000) badCount++;
  endtask

  task automatic finish_test;
    if (badCount == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (10000) @(posedge clk);
    badCount++;
    finish_test;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    rstn = 1'h0;
    wbCycI = 1'h0;
    wbStbI = 1'h0;
    wbWeI = 1'h0;
    wbAdrI = '0;
    wbSelI = 4'hF;
    wbDatI = 32'h00000000;
    badCount = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    cmpBit(txdO, 1'h1);
    cmpBit(txdOeN, 1'h1);
    cmpBit(irqO, 1'h0);
    cmpReg({16'h0000, irqVectorO}, 32'h00000000);
    rstn <= 1'h1;
    foreach (rows[i]) begin
      if (rows[i].we) begin
        busCycle(1'h1, rows[i].idx, rows[i].data);
      end else begin
        readCheck(rows[i].idx, rows[i].data);
      end
    end
    // Data character while asleep
    u_mdaw_node_model.send_frame(8'h55, 1'h0);
    repeat (20) @(posedge clk);
    readCheck(IDX_CTRL, 32'h00000B66);
    readCheck(IDX_STAT, 32'h00000000, 32'h00000084);
    readCheck(IDX_EVT, 32'h00000000);
    cmpBit(irqO, 1'h0);
    // Address then data with no idle gap
    fork
      begin
        u_mdaw_node_model.send_frame(8'hA5, 1'h1);
        u_mdaw_node_model.send_frame(8'h3C, 1'h0);
      end
      begin
        repeat (188) @(posedge clk);
        readCheck(IDX_CTRL, 32'h00000B26);
        readCheck(IDX_STAT, 32'h00000084, 32'h00000084);
        cmpBit(irqO, 1'h1);
        cmpReg({16'h0000, irqVectorO}, 32'h00000014);
      end
    join
    repeat (20) @(posedge clk);
    readCheck(IDX_EVT, 32'h00000003);
    cmpReg({16'h0000, irqVectorO}, 32'h00000016);
    readCheck(IDX_STAT, 32'h00000000, 32'h00000080);
    readCheck(IDX_DATA, 32'h000000A5);
    busCycle(1'h1, IDX_EVT, 32'h00000003);
    readCheck(IDX_EVT, 32'h00000000);
    cmpBit(irqO, 1'h0);
    // Sleep again with the interrupt masked
    busCycle(1'h1, IDX_MASK, 32'h00000000);
    busCycle(1'h1, IDX_CTRL, 32'h00000B66);
    u_mdaw_node_model.send_frame(8'h11, 1'h1);
    repeat (20) @(posedge clk);
    cmpBit(irqO, 1'h0);
    readCheck(IDX_EVT, 32'h00000001);
    readCheck(IDX_CTRL, 32'h00000B26);
    readCheck(IDX_DATA, 32'h00000011);
    busCycle(1'h1, IDX_MASK, 32'h00000007);
    repeat (2) @(posedge clk);
    cmpBit(irqO, 1'h1);
    busCycle(1'h1, IDX_EVT, 32'h00000007);
    repeat (2) @(posedge clk);
    cmpBit(irqO, 1'h0);
    // Wake select clear: an address frame leaves the receiver asleep
    busCycle(1'h1, IDX_CTRL, 32'h00000B46);
    u_mdaw_node_model.send_frame(8'h22, 1'h1);
    repeat (20) @(posedge clk);
    readCheck(IDX_CTRL, 32'h00000B46);
    readCheck(IDX_STAT, 32'h00000080, 32'h00000084);
    readCheck(IDX_EVT, 32'h00000000);
    // Ten-bit format, awake: the ninth line bit reads as stop
    busCycle(1'h1, IDX_CTRL, 32'h00000B00);
    u_mdaw_node_model.send_frame(8'h3C, 1'h1);
    repeat (20) @(posedge clk);
    readCheck(IDX_EVT, 32'h00000001);
    readCheck(IDX_DATA, 32'h0000003C);
    busCycle(1'h1, IDX_EVT, 32'h00000007);
    busCycle(1'h1, IDX_CTRL, 32'h00001B26);
    // Transmit address word then data word
    busCycle(1'h1, IDX_TXA, 32'h0000005A);
    repeat (40) @(posedge clk);
    cmpBit(txdOeN, 1'h0);
    cmpReg({16'h0000, irqVectorO}, 32'h00000018);
    waitHeard(1);
    cmpReg({24'h000000, heardByte}, 32'h0000005A);
    cmpBit(heardNinth, 1'h1);
    cmpBit(heardStop, 1'h1);
    busCycle(1'h1, IDX_DATA, 32'h000000C3);
    waitHeard(2);
    cmpReg({24'h000000, heardByte}, 32'h000000C3);
    cmpBit(heardNinth, 1'h0);
    finish_test;
  end
endmodule
